// >>> shared/cci_pkg.sv
// constants, types and encodings for the calibration command interpreter
// assumes a 125 MHz system clock and a deframer that delivers whole command frames
package cci_pkg;

  // timing
  localparam int CLK_HZ = 125_000_000;
  localparam int LISTEN_MS = 6;
  localparam int LISTEN_CYC = LISTEN_MS * (CLK_HZ / 1000);
  localparam int RAMP_US = 125;
  localparam int RAMP_CYC = RAMP_US * (CLK_HZ / 1_000_000);
  localparam int SAMPLE_HZ = 512_000;
  localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
  localparam int SAMPLE_W = 8;

  // command codes (upper byte of the 16-bit word)
  localparam logic [7:0] CMD_READ_EEPROM = 8'h00;
  localparam logic [7:0] CMD_TEST = 8'h20;
  localparam logic [7:0] CMD_TRIM = 8'h30;
  localparam logic [7:0] CMD_MODE = 8'h40;
  localparam logic [7:0] CMD_ENTER = 8'h50;
  localparam logic [7:0] CMD_SECOND_ORDER = 8'h60;
  localparam logic [7:0] CMD_TEMP_SETPOINT = 8'h70;
  localparam logic [7:0] CMD_GAIN_B_HI = 8'h80;
  localparam logic [7:0] CMD_GAIN_B_LO = 8'h90;
  localparam logic [7:0] CMD_OFFSET_B_HI = 8'ha0;
  localparam logic [7:0] CMD_OFFSET_B_LO = 8'hb0;
  localparam logic [7:0] CMD_GAIN_T = 8'hc0;
  localparam logic [7:0] CMD_OFFSET_T = 8'hd0;
  localparam logic [7:0] CMD_TEMPCO_OFF = 8'he0;
  localparam logic [7:0] CMD_TEMPCO_GAIN = 8'hf0;

  localparam logic [3:0] TEST_NIBBLE = 4'h5;
  localparam logic [7:0] DATA_LEAVE = 8'h00;
  localparam logic [7:0] DATA_RAW = 8'h10;
  localparam logic [7:0] ACK_BYTE = 8'ha5;

  // trim/configure selectors
  localparam logic [3:0] SEL_OSC = 4'h0;
  localparam logic [3:0] SEL_VREF = 4'h1;
  localparam logic [3:0] SEL_OFFSET_MODE = 4'h2;
  localparam logic [3:0] SEL_OUT_MODE = 4'h3;
  localparam logic [3:0] SEL_UPDATE = 4'h4;
  localparam logic [3:0] SEL_REGULATOR = 4'h5;
  localparam logic [3:0] SEL_TEMPCO_CFG = 4'h6;
  localparam logic [3:0] SEL_SECOND_CFG = 4'h7;

  // unity gains that make raw output meaningful, and the analog output mode code
  localparam logic [14:0] GAIN_B_UNITY = 15'h0800;
  localparam logic [7:0] GAIN_T_UNITY = 8'h80;
  localparam logic [1:0] OUT_MODE_ANALOG = 2'h0;

  // register port map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_GAIN_B = 8'h08;
  localparam logic [7:0] ADDR_OFFSET_B = 8'h0c;
  localparam logic [7:0] ADDR_CONFIG = 8'h10;
  localparam logic [7:0] ADDR_COEF_T = 8'h14;
  localparam int CTRL_ODD_PAR = 0;
  localparam int CTRL_CLR_ERR = 1;

  typedef enum logic [1:0] {
    CCI_LISTEN,
    CCI_NORMAL,
    CCI_COMMAND
  } cci_mode_t;

  typedef struct packed {
    logic valid;
    logic timeout;
    logic [7:0] cmd;
    logic cmd_par;
    logic [7:0] data;
    logic data_par;
  } cci_frame_t;

  typedef struct packed {
    logic [14:0] gain_b;
    logic [13:0] offset_b;
    logic [7:0] gain_t;
    logic [7:0] offset_t;
    logic [7:0] second_order_coef;
    logic [7:0] temp_setpoint_coef;
    logic [7:0] tempco_off;
    logic [7:0] tempco_gain;
  } cci_coef_t;

  typedef struct packed {
    logic [2:0] osc_trim;
    logic [3:0] vref_trim;
    logic [1:0] offset_mode;
    logic [1:0] out_mode;
    logic [1:0] update_rate;
    logic [3:0] regulator;
    logic [3:0] tempco_config;
    logic [3:0] second_order_config;
  } cci_cfg_t;

endpackage : cci_pkg

// >>> rtl/cci_interp.sv
// calibration command interpreter: power-up listen window, command mode, decode and acknowledge
// assumes an external deframer hands over one checked-field frame per valid pulse, and an
// external transmitter sends ack_byte whenever ack_send pulses
//
// Summary of operation
// - listen 6 ms after reset release
// - no frame in window: normal run
// - normal run outputs analog or digital data
// - enter command in window starts command mode
// - acknowledge each executed command with a5
// - command mode held until leave command
// - window ignores everything except enter command
// - upper byte command, lower byte data
// - code 00 dumps eeprom on output
// - code 20 nibble 5 enters test mode
// - dac ramp from gain, add offset/8
// - code 30: selector nibble, value nibble
// - code 40 data 00 leaves command mode
// - code 40 data 10 enters raw mode
// - code 50 is the enter command
// - codes 60..f0 store coefficient bytes
// - codes 80/90 program bridge gain halves
// - codes a0/b0 program bridge offset halves
// - selectors 0/1 trim oscillator and reference
// - selectors 2..4 set modes and rate
// - selectors 5..7 regulator, tempco, eeprom bits
// - check parity and timeouts before executing
// - nineteen-bit frames, sampled at 512 kHz
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps

module cci_interp #(
  parameter int LISTEN_CYCLES = cci_pkg::LISTEN_CYC,
  parameter int RAMP_CYCLES = cci_pkg::RAMP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire cci_pkg::cci_frame_t frame,
  output logic sample_tick,
  output logic ack_send,
  output logic [7:0] ack_byte,
  output logic eeprom_dump,
  output cci_pkg::cci_mode_t mode,
  output logic run_active,
  output logic out_digital,
  output logic out_analog,
  output logic test_active,
  output logic [3:0] test_sel,
  output logic [10:0] dac_ramp,
  output logic raw_output_mode,
  output logic raw_active,
  output cci_pkg::cci_coef_t coef,
  output cci_pkg::cci_cfg_t cfg,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  localparam int LW = $clog2(LISTEN_CYCLES + 1);
  localparam int RW = $clog2(RAMP_CYCLES + 1);
  localparam logic [LW-1:0] LISTEN_LAST = LW'(LISTEN_CYCLES - 1);
  localparam logic [RW-1:0] RAMP_LAST = RW'(RAMP_CYCLES - 1);
  localparam logic [cci_pkg::SAMPLE_W-1:0] SAMPLE_LAST = cci_pkg::SAMPLE_W'(cci_pkg::SAMPLE_DIV - 1);

  logic odd_parity;
  logic frame_err;
  logic [LW-1:0] listen_cnt;
  logic [RW-1:0] ramp_cnt;
  logic [cci_pkg::SAMPLE_W-1:0] sample_cnt;

  // decoded fields of the incoming word
  logic [7:0] cmd;
  logic [7:0] data;
  logic [3:0] sel;
  logic [3:0] val;
  logic par_ok;
  logic good;
  logic known;
  logic exec;
  logic is_enter;
  logic listen_done;

  assign cmd = frame.cmd;
  assign data = frame.data;
  assign sel = frame.data[7:4];
  assign val = frame.data[3:0];

  // parity on both bytes, no timeout
  assign par_ok = ((^cmd) ^ frame.cmd_par) == odd_parity && ((^data) ^ frame.data_par) == odd_parity;
  assign good = frame.valid && !frame.timeout && par_ok;

  // enter code accepts any data byte
  assign is_enter = cmd == cci_pkg::CMD_ENTER;
  assign listen_done = listen_cnt == LISTEN_LAST;

  // only recognised codes execute and acknowledge
  always_comb begin
    known = 1'b0;
    case (cmd)
      cci_pkg::CMD_READ_EEPROM: known = 1'b1;
      cci_pkg::CMD_TEST: known = sel == cci_pkg::TEST_NIBBLE;
      cci_pkg::CMD_TRIM: known = sel <= cci_pkg::SEL_SECOND_CFG;
      cci_pkg::CMD_MODE: known = data == cci_pkg::DATA_LEAVE || data == cci_pkg::DATA_RAW;
      cci_pkg::CMD_ENTER: known = 1'b1;
      cci_pkg::CMD_SECOND_ORDER: known = 1'b1;
      cci_pkg::CMD_TEMP_SETPOINT: known = 1'b1;
      cci_pkg::CMD_GAIN_B_HI: known = 1'b1;
      cci_pkg::CMD_GAIN_B_LO: known = 1'b1;
      cci_pkg::CMD_OFFSET_B_HI: known = 1'b1;
      cci_pkg::CMD_OFFSET_B_LO: known = 1'b1;
      cci_pkg::CMD_GAIN_T: known = 1'b1;
      cci_pkg::CMD_OFFSET_T: known = 1'b1;
      cci_pkg::CMD_TEMPCO_OFF: known = 1'b1;
      cci_pkg::CMD_TEMPCO_GAIN: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // commands execute only inside command mode
  assign exec = good && known && mode == cci_pkg::CCI_COMMAND;

  // 512 kHz sample strobe for the line deframer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sample_cnt <= '0;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= sample_cnt == SAMPLE_LAST;
      if (sample_cnt == SAMPLE_LAST) begin
        sample_cnt <= '0;
      end else begin
        sample_cnt <= sample_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      listen_cnt <= '0;
    end else if (mode == cci_pkg::CCI_LISTEN && !listen_done) begin
      listen_cnt <= listen_cnt + 1'b1;
    end
  end

  // operating mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode <= cci_pkg::CCI_LISTEN;
    end else begin
      case (mode)
        cci_pkg::CCI_LISTEN: begin
          // only the enter command opens command mode
          if (good && is_enter) begin
            mode <= cci_pkg::CCI_COMMAND;
          end else if (listen_done) begin
            mode <= cci_pkg::CCI_NORMAL;
          end
        end
        cci_pkg::CCI_COMMAND: begin
          if (exec && cmd == cci_pkg::CMD_MODE && data == cci_pkg::DATA_LEAVE) begin
            mode <= cci_pkg::CCI_NORMAL;
          end
        end
        cci_pkg::CCI_NORMAL: mode <= cci_pkg::CCI_NORMAL;
        default: mode <= cci_pkg::CCI_LISTEN;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_send <= 1'b0;
      ack_byte <= cci_pkg::ACK_BYTE;
    end else begin
      ack_send <= exec || (mode == cci_pkg::CCI_LISTEN && good && is_enter);
      ack_byte <= cci_pkg::ACK_BYTE;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      eeprom_dump <= 1'b0;
    end else begin
      eeprom_dump <= exec && cmd == cci_pkg::CMD_READ_EEPROM;
    end
  end

  // test mode and raw mode flags; leaving command mode clears only the test flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      test_active <= 1'b0;
      test_sel <= '0;
      raw_output_mode <= 1'b0;
    end else if (exec) begin
      // test point chosen by upper nibble
      if (cmd == cci_pkg::CMD_TEST) begin
        test_active <= 1'b1;
        test_sel <= sel;
      end
      if (cmd == cci_pkg::CMD_MODE && data == cci_pkg::DATA_RAW) begin
        raw_output_mode <= 1'b1;
      end
      if (cmd == cci_pkg::CMD_MODE && data == cci_pkg::DATA_LEAVE) begin
        test_active <= 1'b0;
      end
    end
  end

  // dac ramp: load on test entry, step every 125 us
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ramp_cnt <= '0;
      dac_ramp <= '0;
    end else if (exec && cmd == cci_pkg::CMD_TEST) begin
      ramp_cnt <= '0;
      dac_ramp <= coef.gain_b[13:3];
    end else if (test_active) begin
      if (ramp_cnt == RAMP_LAST) begin
        ramp_cnt <= '0;
        // wraps at 11 bits, as a ramp test should
        dac_ramp <= dac_ramp + coef.offset_b[13:3];
      end else begin
        ramp_cnt <= ramp_cnt + 1'b1;
      end
    end
  end

  // coefficient storage; working copy updated at once
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      coef <= '0;
    end else if (exec) begin
      case (cmd)
        cci_pkg::CMD_SECOND_ORDER: coef.second_order_coef <= data;
        cci_pkg::CMD_TEMP_SETPOINT: coef.temp_setpoint_coef <= data;
        cci_pkg::CMD_GAIN_T: coef.gain_t <= data;
        cci_pkg::CMD_OFFSET_T: coef.offset_t <= data;
        cci_pkg::CMD_TEMPCO_OFF: coef.tempco_off <= data;
        cci_pkg::CMD_TEMPCO_GAIN: coef.tempco_gain <= data;
        // gain halves, top data bit dropped
        cci_pkg::CMD_GAIN_B_HI: coef.gain_b[14:8] <= data[6:0];
        cci_pkg::CMD_GAIN_B_LO: coef.gain_b[7:0] <= data;
        // offset halves, two top bits dropped
        cci_pkg::CMD_OFFSET_B_HI: coef.offset_b[13:8] <= data[5:0];
        cci_pkg::CMD_OFFSET_B_LO: coef.offset_b[7:0] <= data;
        default: coef <= coef;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg <= '0;
    end else if (exec && cmd == cci_pkg::CMD_TRIM) begin
      case (sel)
        // oscillator 3 bits, reference 4 bits
        cci_pkg::SEL_OSC: cfg.osc_trim <= val[2:0];
        cci_pkg::SEL_VREF: cfg.vref_trim <= val;
        cci_pkg::SEL_OFFSET_MODE: cfg.offset_mode <= val[1:0];
        cci_pkg::SEL_OUT_MODE: cfg.out_mode <= val[1:0];
        cci_pkg::SEL_UPDATE: cfg.update_rate <= val[1:0];
        // regulator, tempco and eeprom bits 99..96
        cci_pkg::SEL_REGULATOR: cfg.regulator <= val;
        cci_pkg::SEL_TEMPCO_CFG: cfg.tempco_config <= val;
        cci_pkg::SEL_SECOND_CFG: cfg.second_order_config <= val;
        default: cfg <= cfg;
      endcase
    end
  end

  // run output path follows configured mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run_active <= 1'b0;
      out_digital <= 1'b0;
      out_analog <= 1'b0;
    end else begin
      run_active <= mode == cci_pkg::CCI_NORMAL;
      out_digital <= mode == cci_pkg::CCI_NORMAL && cfg.out_mode != cci_pkg::OUT_MODE_ANALOG;
      out_analog <= mode == cci_pkg::CCI_NORMAL && cfg.out_mode == cci_pkg::OUT_MODE_ANALOG;
    end
  end

  // raw values only with unity gains
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      raw_active <= 1'b0;
    end else begin
      raw_active <= raw_output_mode && coef.gain_b == cci_pkg::GAIN_B_UNITY && coef.gain_t == cci_pkg::GAIN_T_UNITY;
    end
  end

  // register port: control
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      odd_parity <= 1'b0;
    end else if (reg_wr && reg_addr == cci_pkg::ADDR_CTRL) begin
      odd_parity <= reg_wdata[cci_pkg::CTRL_ODD_PAR];
    end
  end

  // sticky record of dropped frames; a new error beats a clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      frame_err <= 1'b0;
    end else if (frame.valid && !good) begin
      frame_err <= 1'b1;
    end else if (reg_wr && reg_addr == cci_pkg::ADDR_CTRL && reg_wdata[cci_pkg::CTRL_CLR_ERR]) begin
      frame_err <= 1'b0;
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        cci_pkg::ADDR_CTRL: reg_rdata <= {31'h0, odd_parity};
        cci_pkg::ADDR_STATUS: reg_rdata <= {25'h0, frame_err, raw_active, raw_output_mode, test_active, 1'b0, mode};
        cci_pkg::ADDR_GAIN_B: reg_rdata <= {17'h0, coef.gain_b};
        cci_pkg::ADDR_OFFSET_B: reg_rdata <= {18'h0, coef.offset_b};
        cci_pkg::ADDR_CONFIG: reg_rdata <= {7'h0, cfg};
        cci_pkg::ADDR_COEF_T: reg_rdata <= {coef.gain_t, coef.offset_t, coef.tempco_off, coef.tempco_gain};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : cci_interp

// >>> dv/cci_interp_monitor.sv
// port checker for the calibration command interpreter
// assumes even parity until the control register selects odd
`timescale 1ns/10ps
module cci_interp_monitor #(
  parameter int LISTEN_CYCLES = 750000,
  parameter int RAMP_CYCLES = 15625
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire cci_pkg::cci_frame_t frame,
  input wire logic sample_tick,
  input wire logic ack_send,
  input wire logic [7:0] ack_byte,
  input wire logic eeprom_dump,
  input wire cci_pkg::cci_mode_t mode,
  input wire logic run_active,
  input wire logic out_digital,
  input wire logic out_analog,
  input wire logic test_active,
  input wire logic [10:0] dac_ramp,
  input wire cci_pkg::cci_coef_t coef,
  input wire cci_pkg::cci_cfg_t cfg,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr
);
  logic odd;
  logic good;
  logic [10:0] ofs8;
  int unsigned age;
  assign good = frame.valid && !frame.timeout && ((^frame.cmd ^ frame.cmd_par) == odd)
    && ((^frame.data ^ frame.data_par) == odd);
  assign ofs8 = coef.offset_b[13:3];
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) odd <= 1'b0;
    else if (reg_wr && reg_addr == cci_pkg::ADDR_CTRL) odd <= reg_wdata[cci_pkg::CTRL_ODD_PAR];
  end
  // saturates so a long run never wraps the age
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) age <= 0;
    else if (age < LISTEN_CYCLES + 4) age <= age + 1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ack_cause_a: assert property (ack_send |-> ack_byte == 8'ha5 && $past(good))
    else $error("ack without an executed frame");
  bad_frame_a: assert property (frame.valid && !good |=> !ack_send)
    else $error("bad frame acknowledged");
  listen_lock_a: assert property (frame.valid && mode == cci_pkg::CCI_LISTEN && frame.cmd != 8'h50
    |=> !ack_send && mode != cci_pkg::CCI_COMMAND) else $error("listen accepted a non-enter frame");
  enter_cmd_a: assert property (good && mode == cci_pkg::CCI_LISTEN && frame.cmd == 8'h50
    |=> mode == cci_pkg::CCI_COMMAND && ack_send) else $error("enter frame not taken");
  hold_cmd_a: assert property (mode == cci_pkg::CCI_COMMAND && !(frame.valid && frame.cmd == 8'h40)
    |=> mode == cci_pkg::CCI_COMMAND) else $error("command mode left on its own");
  leave_cmd_a: assert property (good && mode == cci_pkg::CCI_COMMAND && frame.cmd == 8'h40
    && frame.data == 8'h00 |=> mode == cci_pkg::CCI_NORMAL && ack_send ##1 run_active)
    else $error("leave frame not taken");
  normal_quiet_a: assert property (mode == cci_pkg::CCI_NORMAL
    |=> mode == cci_pkg::CCI_NORMAL && !ack_send && !eeprom_dump) else $error("normal run disturbed");
  window_end_a: assert property (mode == cci_pkg::CCI_NORMAL && $past(mode) == cci_pkg::CCI_LISTEN
    |-> age + 1 >= LISTEN_CYCLES && age <= LISTEN_CYCLES + 2) else $error("listen window length wrong");
  out_select_a: assert property (mode == cci_pkg::CCI_NORMAL [*3] |-> run_active
    && out_digital == (cfg.out_mode != 2'h0) && out_analog == (cfg.out_mode == 2'h0))
    else $error("output kind does not follow out_mode");
  dump_cause_a: assert property (eeprom_dump |-> ack_send && $past(good)
    && $past(frame.cmd) == 8'h00 && $past(mode) == cci_pkg::CCI_COMMAND) else $error("stray eeprom dump");
  ramp_step_a: assert property (test_active && $past(test_active) && !$past(frame.valid)
    && dac_ramp != $past(dac_ramp) |-> dac_ramp == 11'($past(dac_ramp) + $past(ofs8)))
    else $error("ramp step is not offset/8");
  tick_gap_a: assert property (sample_tick |=> !sample_tick [*8])
    else $error("sample ticks too close");
  cover property (mode == cci_pkg::CCI_COMMAND && $past(mode) == cci_pkg::CCI_LISTEN);
  cover property (mode == cci_pkg::CCI_NORMAL && $past(mode) == cci_pkg::CCI_COMMAND);
  cover property (eeprom_dump);
  cover property (test_active && $changed(dac_ramp));
endmodule : cci_interp_monitor

bind cci_interp cci_interp_monitor #(.LISTEN_CYCLES(LISTEN_CYCLES), .RAMP_CYCLES(RAMP_CYCLES)) mon_u (
  .sys_clk(sys_clk), .rst(rst), .frame(frame), .sample_tick(sample_tick), .ack_send(ack_send),
  .ack_byte(ack_byte), .eeprom_dump(eeprom_dump), .mode(mode), .run_active(run_active),
  .out_digital(out_digital), .out_analog(out_analog), .test_active(test_active), .dac_ramp(dac_ramp),
  .coef(coef), .cfg(cfg), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr));

// >>> dv/cci_master_model.sv
// calibration master model: hands whole checked frames to the interpreter
// assumes the frame fields stand for a deframer output, one valid pulse a frame
`timescale 1ns/10ps
module cci_master_model (
  input wire logic sys_clk,
  input wire logic ack_send,
  output cci_pkg::cci_frame_t frame
);
  logic got_ack;
  initial frame = '0;
  task automatic send(input logic [7:0] c, input logic [7:0] d, input logic [1:0] bad);
    @(posedge sys_clk);
    // bad[0] flips both parity bits, so it also makes a frame that is good under odd parity
    frame <= {1'b1, bad[1], c, ^c ^ bad[0], d, ^d ^ bad[0]};
    @(posedge sys_clk);
    // released fields show the inverse so stale values never pass
    frame <= {2'b00, ~c, 1'b0, ~d, 1'b0};
    @(negedge sys_clk);
    // silence means not executed; the answer is due long before 130 ms
    got_ack = ack_send;
  endtask : send
endmodule : cci_master_model

// >>> dv/cci_interp_tb.sv
// self-checking bench for the calibration command interpreter
// assumes the master model drives frames; listen and ramp counts are shortened
`timescale 1ns/10ps
module cci_interp_tb;
  localparam int LW = 300;
  logic sys_clk, rst, reg_wr, reg_rd, fv, rv;
  logic sample_tick, ack_send, eeprom_dump, run_active, out_digital, out_analog;
  logic test_active, raw_output_mode, raw_active;
  logic [3:0] test_sel;
  logic [10:0] dac_ramp;
  logic [7:0] reg_addr, ack_byte, d;
  logic [31:0] reg_wdata, reg_rdata;
  cci_pkg::cci_frame_t frame;
  cci_pkg::cci_mode_t mode;
  cci_pkg::cci_coef_t coef, ec;
  cci_pkg::cci_cfg_t cfg, eg;
  logic aq[$];
  logic [31:0] rq[$];
  int failures, tests_run;
  cci_interp #(.LISTEN_CYCLES(LW), .RAMP_CYCLES(8)) dut_u (.sys_clk(sys_clk), .rst(rst), .frame(frame),
    .sample_tick(sample_tick), .ack_send(ack_send), .ack_byte(ack_byte), .eeprom_dump(eeprom_dump),
    .mode(mode), .run_active(run_active), .out_digital(out_digital), .out_analog(out_analog),
    .test_active(test_active), .test_sel(test_sel), .dac_ramp(dac_ramp), .raw_output_mode(raw_output_mode),
    .raw_active(raw_active), .coef(coef), .cfg(cfg), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  cci_master_model m_u (.sys_clk(sys_clk), .ack_send(ack_send), .frame(frame));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // results are due one cycle after the frame or read strobe
  always @(posedge sys_clk) begin
    if (fv) check(128'({ack_send, ack_byte}), 128'({aq.pop_front(), 8'ha5}));
    if (rv) check(128'(reg_rdata), 128'(rq.pop_front()));
    fv <= frame.valid;
    rv <= reg_rd;
  end
  task automatic fr(input logic [7:0] c, input logic [7:0] v, input logic [1:0] bad, input logic ok);
    aq.push_back(ok);
    m_u.send(c, v, bad);
    check(128'(m_u.got_ack), 128'(ok));
  endtask : fr
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, fv, rv, reg_addr, reg_wdata} = '0;
    void'($urandom(32'h3a26));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    check(128'(mode), 128'(cci_pkg::CCI_LISTEN));
    fr(8'h60, 8'h12, 2'b00, 1'b0);
    fr(8'h50, 8'h00, 2'b01, 1'b0);
    fr(8'h50, 8'h3c, 2'b00, 1'b1);
    check(128'(mode), 128'(cci_pkg::CCI_COMMAND));
    fr(8'h60, 8'h77, 2'b10, 1'b0);
    rd(cci_pkg::ADDR_STATUS, 32'h42);
    wr(cci_pkg::ADDR_CTRL, 32'h2);
    rd(cci_pkg::ADDR_STATUS, 32'h02);
    rd(8'h40, 32'h0);
    $display("listen and interlock done");
    ec = '0;
    for (int i = 6; i < 16; i++) begin
      d = 8'($urandom);
      case (i)
        6: ec.second_order_coef = d;
        7: ec.temp_setpoint_coef = d;
        // top data bit sent as zero
        8: begin d[7] = 1'b0; ec.gain_b[14:8] = d[6:0]; end
        9: ec.gain_b[7:0] = d;
        // two top data bits sent as zero
        10: begin d[7:6] = 2'b00; ec.offset_b[13:8] = d[5:0]; end
        11: ec.offset_b[7:0] = d;
        12: ec.gain_t = d;
        13: ec.offset_t = d;
        14: ec.tempco_off = d;
        default: ec.tempco_gain = d;
      endcase
      fr(8'(i * 16), d, 2'b00, 1'b1);
      check(128'(coef), 128'(ec));
    end
    fr(8'h61, 8'h55, 2'b00, 1'b0);
    check(128'(coef), 128'(ec));
    wr(cci_pkg::ADDR_CTRL, 32'h1);
    fr(8'h60, 8'h12, 2'b01, 1'b1);
    fr(8'h60, 8'h34, 2'b00, 1'b0);
    wr(cci_pkg::ADDR_CTRL, 32'h2);
    ec.second_order_coef = 8'h12;
    check(128'(coef), 128'(ec));
    rd(cci_pkg::ADDR_GAIN_B, 32'(ec.gain_b));
    $display("coefficients done");
    eg = '0;
    for (int s = 0; s < 9; s++) begin
      d = {4'(s), 4'($urandom)};
      case (s)
        0: eg.osc_trim = d[2:0];
        1: eg.vref_trim = d[3:0];
        2: eg.offset_mode = d[1:0];
        3: eg.out_mode = d[1:0];
        4: eg.update_rate = d[1:0];
        5: eg.regulator = d[3:0];
        6: eg.tempco_config = d[3:0];
        7: eg.second_order_config = d[3:0];
        default: ;
      endcase
      fr(8'h30, d, 2'b00, s < 8);
      check(128'(cfg), 128'(eg));
    end
    $display("trim and configure done");
    fr(8'h00, 8'($urandom), 2'b00, 1'b1);
    check(128'(eeprom_dump), 128'(1));
    fr(8'h20, 8'h6a, 2'b00, 1'b0);
    fr(8'h20, 8'h5a, 2'b00, 1'b1);
    check(128'({test_active, test_sel, dac_ramp}), 128'({1'b1, 4'h5, ec.gain_b[13:3]}));
    for (int n = 0; n < 40 && dac_ramp === ec.gain_b[13:3]; n++) @(negedge sys_clk);
    check(128'(dac_ramp), 128'(11'(ec.gain_b[13:3] + ec.offset_b[13:3])));
    $display("eeprom and test mode done");
    fr(8'h80, 8'h08, 2'b00, 1'b1);
    fr(8'h90, 8'h00, 2'b00, 1'b1);
    fr(8'hc0, 8'h80, 2'b00, 1'b1);
    fr(8'h40, 8'h10, 2'b00, 1'b1);
    repeat (2) @(negedge sys_clk);
    check(128'({raw_output_mode, raw_active}), 128'(2'b11));
    fr(8'h40, 8'h00, 2'b00, 1'b1);
    check(128'({mode, test_active}), 128'({cci_pkg::CCI_NORMAL, 1'b0}));
    fr(8'h50, 8'h00, 2'b00, 1'b0);
    repeat (4) @(negedge sys_clk);
    check(128'({run_active, out_digital, out_analog}), 128'({1'b1, eg.out_mode != 2'h0, eg.out_mode == 2'h0}));
    $display("raw mode and leave done");
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (LW - 5) @(negedge sys_clk);
    check(128'(mode), 128'(cci_pkg::CCI_LISTEN));
    repeat (10) @(negedge sys_clk);
    check(128'({mode, out_analog}), 128'({cci_pkg::CCI_NORMAL, 1'b1}));
    $display("window expiry done");
    complete_run();
  end
endmodule : cci_interp_tb
